// ---- hw/pwr_pkg.sv ----
package pwr_pkg;

  // ----------------------------------------------------------------
  // Clock and timing.
  // ----------------------------------------------------------------
  // System clock rate in hertz.
  localparam int CLK_HZ = 20_000_000;
  // Output rates in hertz, indexed by the rate select code.
  localparam int RATE0_HZ = 22500;
  localparam int RATE1_HZ = 96;
  localparam int RATE2_HZ = 84;
  localparam int RATE3_HZ = 72;
  localparam int RATE4_HZ = 60;
  localparam int RATE5_HZ = 48;
  localparam int RATE6_HZ = 36;
  localparam int RATE7_HZ = 12;
  // Slices per output period for the fine high rate map and for the low rate map.
  localparam int DIV_FINE = 16;
  localparam int DIV_LOW = 28;
  // Cycles per slice at the high rate, rounded down so the rate never falls short.
  localparam int SLICE_HI_FINE = CLK_HZ / (RATE0_HZ * DIV_FINE);
  localparam int SLICE_HI_LOW = CLK_HZ / (RATE0_HZ * DIV_LOW);

  // ----------------------------------------------------------------
  // Register map.
  // ----------------------------------------------------------------
  // Offset of the rate and map control register.
  localparam logic [7:0] CTRL_ADDR = 8'hCF;
  // Reset value of the control register.
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Field positions.
  localparam int RATE_LSB = 0;
  localparam int RATE_MSB = 2;
  localparam int MAP_BIT = 3;
  // Rate code that selects the high rate.
  localparam logic [2:0] RATE_HIGH_CODE = 3'h0;

  // ----------------------------------------------------------------
  // Duty steps.
  // ----------------------------------------------------------------
  // Highest table step; step zero means no request.
  localparam logic [3:0] STEP_MAX = 4'hD;
  // Fine map starts at four sixteenths for step one.
  localparam logic [4:0] FINE_OFFSET = 5'h03;
  // Low map starts at seven of twenty-eight for step one.
  localparam logic [4:0] LOW_OFFSET = 5'h06;
  // Last step of the even part of the low map, then the three coarse steps.
  localparam logic [3:0] LOW_LINEAR_LAST = 4'hA;
  localparam logic [4:0] LOW_STEP11 = 5'h14;
  localparam logic [4:0] LOW_STEP12 = 5'h18;
  localparam logic [4:0] LOW_STEP13 = 5'h1C;
  // Number of duty sources that may request a step.
  localparam int NUM_SRC = 8;

  // Whole state of the generator.
  typedef struct packed {
    logic [3:0] ctrl;
    logic [16:0] slice_cnt;
    logic [4:0] slice_idx;
    logic [4:0] num_lat;
    logic [4:0] div_lat;
    logic pwm;
    logic [7:0] rdata;
  } pwr_state_t;

endpackage

// ---- hw/pwr_rate_map.sv ----
`timescale 1ns/10ps
// Function
// - Control bits 2:0 set output rate.
// - Codes give 22500,96,84,72,60,48,36,12 Hz.
// - Bit 3 picks duty map at high rate.
// - Chosen map serves every duty source.
// - Map clear: 25% plus 6.25% per step.
// - Map set: low rate 28-slice map used.
// - Other rates always use low map.
// - Thirteen steps, last step is full duty.
module pwr_rate_map
  import pwr_pkg::*;
#(
  parameter int SLICE_R1 = CLK_HZ / (RATE1_HZ * DIV_LOW),
  parameter int SLICE_R2 = CLK_HZ / (RATE2_HZ * DIV_LOW),
  parameter int SLICE_R3 = CLK_HZ / (RATE3_HZ * DIV_LOW),
  parameter int SLICE_R4 = CLK_HZ / (RATE4_HZ * DIV_LOW),
  parameter int SLICE_R5 = CLK_HZ / (RATE5_HZ * DIV_LOW),
  parameter int SLICE_R6 = CLK_HZ / (RATE6_HZ * DIV_LOW),
  parameter int SLICE_R7 = CLK_HZ / (RATE7_HZ * DIV_LOW)
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Register port from the serial management interface.
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  output logic [7:0] reg_rd_data,
  // Duty requests: four tables, regulator ramp, hot ramp, spin-up, override.
  input wire logic [NUM_SRC*4-1:0] duty_step_req,
  // Fan output and status.
  output logic pwm_channel_two,
  output logic [3:0] duty_step_applied
);

  // ----------------------------------------------------------------
  // State.
  // ----------------------------------------------------------------
  pwr_state_t state_reg;
  pwr_state_t state_next;
  // Winning step among all requests, clamped to the table.
  logic [3:0] step_win;
  // Steps after clamping, one per source.
  logic [3:0] step_clamp [NUM_SRC];
  // Slices per period and high slices for the current settings.
  logic [4:0] div_cur;
  logic [4:0] num_cur;
  // Cycles per slice for the current rate.
  logic [16:0] slice_len;
  // Decoded control fields.
  logic [2:0] pwm_channel_two_rate_select;
  logic high_rate_duty_map_select;
  logic fine_map;

  assign pwm_channel_two_rate_select = state_reg.ctrl[RATE_MSB:RATE_LSB];
  assign high_rate_duty_map_select = state_reg.ctrl[MAP_BIT];

  // ----------------------------------------------------------------
  // Source clamping.
  // ----------------------------------------------------------------
  // Each source is clamped so an out of range value asks for full duty, not a wrap.
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : g_clamp
      assign step_clamp[g] = (duty_step_req[g*4 +: 4] > STEP_MAX) ? STEP_MAX : duty_step_req[g*4 +: 4];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Map selection.
  // ----------------------------------------------------------------
  // The largest request wins; the one map below then serves whichever source it was.
  always_comb begin
    step_win = 4'h0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (step_clamp[i] > step_win) begin
        step_win = step_clamp[i];
      end
    end
    // The map bit only counts at the high rate.
    fine_map = (pwm_channel_two_rate_select == RATE_HIGH_CODE) && !high_rate_duty_map_select;
    if (step_win == 4'h0) begin
      num_cur = 5'h00;
    end else if (fine_map) begin
      num_cur = {1'b0, step_win} + FINE_OFFSET;
    end else if (step_win <= LOW_LINEAR_LAST) begin
      num_cur = {1'b0, step_win} + LOW_OFFSET;
    end else if (step_win == 4'hB) begin
      num_cur = LOW_STEP11;
    end else if (step_win == 4'hC) begin
      num_cur = LOW_STEP12;
    end else begin
      num_cur = LOW_STEP13;
    end
    div_cur = fine_map ? 5'(DIV_FINE) : 5'(DIV_LOW);
  end

  // ----------------------------------------------------------------
  // Rate decode.
  // ----------------------------------------------------------------
  // Slice length per rate code; the divider keeps the duty grid exact at every rate.
  always_comb begin
    case (pwm_channel_two_rate_select)
      3'h0: slice_len = fine_map ? 17'(SLICE_HI_FINE) : 17'(SLICE_HI_LOW);
      3'h1: slice_len = 17'(SLICE_R1);
      3'h2: slice_len = 17'(SLICE_R2);
      3'h3: slice_len = 17'(SLICE_R3);
      3'h4: slice_len = 17'(SLICE_R4);
      3'h5: slice_len = 17'(SLICE_R5);
      3'h6: slice_len = 17'(SLICE_R6);
      default: slice_len = 17'(SLICE_R7);
    endcase
  end

  // ----------------------------------------------------------------
  // Next state.
  // ----------------------------------------------------------------
  // Duty and grid are latched at period start so a change never makes a runt pulse.
  always_comb begin
    state_next = state_reg;
    // Only the low nibble is writable; the upper bits are not stored at all.
    if (reg_wr_en && (reg_addr == CTRL_ADDR)) begin
      state_next.ctrl = reg_wr_data[3:0];
    end
    // Reads return the control nibble with zeros above.
    state_next.rdata = (reg_addr == CTRL_ADDR) ? {4'h0, state_reg.ctrl} : 8'h00;
    // Slice divider: one enable per slice.
    if (state_reg.slice_cnt + 17'h0_0001 >= slice_len) begin
      state_next.slice_cnt = 17'h0_0000;
      if (state_reg.slice_idx + 5'h01 >= state_reg.div_lat) begin
        // New period: take the current duty and grid.
        state_next.slice_idx = 5'h00;
        state_next.num_lat = num_cur;
        state_next.div_lat = div_cur;
      end else begin
        state_next.slice_idx = state_reg.slice_idx + 5'h01;
      end
    end else begin
      state_next.slice_cnt = state_reg.slice_cnt + 17'h0_0001;
    end
    // High for the first num slices of each period.
    state_next.pwm = state_next.slice_idx < state_next.num_lat;
    if (sys_rst) begin
      state_next = '0;
      state_next.ctrl = CTRL_RESET[3:0];
      state_next.div_lat = 5'(DIV_FINE);
    end
  end

  // ----------------------------------------------------------------
  // State register.
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    state_reg <= state_next;
  end

  assign pwm_channel_two = state_reg.pwm;
  assign reg_rd_data = state_reg.rdata;
  assign duty_step_applied = step_win;

  // ----------------------------------------------------------------
  // Assertions.
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  property p_rate_write;
    reg_wr_en && reg_addr == CTRL_ADDR |=> pwm_channel_two_rate_select == $past(reg_wr_data[2:0]);
  endproperty
  a_rate_write: assert property (p_rate_write) else $error("rate field not written");

  property p_rate_slice;
    pwm_channel_two_rate_select == 3'h7 |-> slice_len == 17'(SLICE_R7);
  endproperty
  a_rate_slice: assert property (p_rate_slice) else $error("slowest rate slice wrong");

  property p_map_fine;
    pwm_channel_two_rate_select == 3'h0 && !high_rate_duty_map_select && step_win == 4'h1 |-> num_cur == 5'h04 && div_cur == 5'h10;
  endproperty
  a_map_fine: assert property (p_map_fine) else $error("fine map step one wrong");

  property p_max_wins;
    step_win >= step_clamp[NUM_SRC-1] && step_win >= step_clamp[0];
  endproperty
  a_max_wins: assert property (p_max_wins) else $error("a larger request was dropped");

  property p_fine_step7;
    fine_map && step_win == 4'h7 |-> num_cur == 5'h0A;
  endproperty
  a_fine_step7: assert property (p_fine_step7) else $error("fine step seven wrong");

  property p_low_step11;
    high_rate_duty_map_select && step_win == 4'hB |-> num_cur == 5'h14 && div_cur == 5'h1C;
  endproperty
  a_low_step11: assert property (p_low_step11) else $error("low map step eleven wrong");

  property p_low_rate;
    pwm_channel_two_rate_select != 3'h0 |-> div_cur == 5'h1C;
  endproperty
  a_low_rate: assert property (p_low_rate) else $error("low rate not on low map");

  property p_full;
    step_win == 4'hD |-> num_cur == div_cur;
  endproperty
  a_full: assert property (p_full) else $error("last step not full duty");

  property p_rsvd;
    reg_rd_data[7:4] == 4'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");

  property p_pwm_shape;
    ##1 $past(state_reg.num_lat) == 5'h00 && state_reg.num_lat == 5'h00 |-> !pwm_channel_two;
  endproperty
  a_pwm_shape: assert property (p_pwm_shape) else $error("output high at zero duty");

  c_fine: cover property (fine_map && step_win == 4'h5);
  c_low_hi: cover property (pwm_channel_two_rate_select == 3'h0 && high_rate_duty_map_select && step_win == 4'hC);
  c_slow: cover property (pwm_channel_two_rate_select == 3'h3 && $rose(pwm_channel_two));
  c_full: cover property (state_reg.num_lat == 5'h1C && pwm_channel_two);

endmodule

// ---- verif/pwr_fan_model.sv ----
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Fan model: measures how long and how often the drive is high.
// ----------------------------------------------------------------
module pwr_fan_model (
  // Clock.
  input wire logic clk_sys,
  // Drive from the block and measuring window length in cycles.
  input wire logic pwm_in,
  input wire logic [15:0] win,
  // High cycles per window and cycles between rising edges.
  output logic [15:0] hi_cnt,
  output logic [15:0] per_cnt
);
  logic [15:0] w_reg = 16'h0000; // Cycles into the window.
  logic [15:0] h_reg = 16'h0000; // High cycles so far.
  logic [15:0] p_reg = 16'h0000; // Cycles since the last rising edge.
  logic last_reg = 1'b0; // Drive level one cycle ago.
  // A window of one whole period gives the same count at any phase, so no sync is needed.
  always_ff @(posedge clk_sys) begin
    last_reg <= pwm_in;
    p_reg <= (pwm_in && !last_reg) ? 16'h0001 : p_reg + 16'h0001;
    if (pwm_in && !last_reg) begin
      per_cnt <= p_reg;
    end
    if (w_reg >= win - 16'h0001) begin
      hi_cnt <= h_reg + {15'h0000, pwm_in};
      h_reg <= 16'h0000;
      w_reg <= 16'h0000;
    end else begin
      h_reg <= h_reg + {15'h0000, pwm_in};
      w_reg <= w_reg + 16'h0001;
    end
  end
endmodule

// ---- verif/tb_pwr_rate_map.sv ----
`timescale 1ns/10ps
module tb_pwr_rate_map;
  import pwr_pkg::*;
  // One case: control byte, step, high cycles and period expected.
  typedef struct {logic [7:0] ctrl; logic [3:0] step; logic [15:0] hi; logic [15:0] per;} pwr_row_t;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr_en = 1'b0;
  logic [7:0] reg_wr_data = 8'h00;
  logic [7:0] reg_rd_data;
  logic [31:0] duty_step_req = 32'h0000_0000;
  logic pwm_channel_two;
  logic [3:0] duty_step_applied;
  logic [15:0] win = 16'h0370;
  logic [15:0] fan_hi;
  logic [15:0] fan_per;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  // Shortest low-rate slice in cycles; each slower code adds one cycle, so the row periods stay short.
  localparam int SL_BASE = 2;
  // Slices are 55 and 31 cycles at the high rate; the low rates get short slices 2 to 8.
  pwr_row_t rows [16] = '{
    '{8'h00, 4'h1, 16'h00DC, 16'h0370}, '{8'h00, 4'h7, 16'h0226, 16'h0370},
    '{8'h00, 4'hD, 16'h0370, 16'h0370}, '{8'h08, 4'h1, 16'h00D9, 16'h0364},
    '{8'h08, 4'hA, 16'h01F0, 16'h0364}, '{8'h08, 4'hB, 16'h026C, 16'h0364},
    '{8'h08, 4'hC, 16'h02E8, 16'h0364}, '{8'h08, 4'hD, 16'h0364, 16'h0364},
    '{8'h01, 4'h2, 16'h0010, 16'h0038}, '{8'h0A, 4'h2, 16'h0018, 16'h0054},
    '{8'h03, 4'h2, 16'h0020, 16'h0070}, '{8'h0C, 4'h2, 16'h0028, 16'h008C},
    '{8'h05, 4'h2, 16'h0030, 16'h00A8}, '{8'h0E, 4'h2, 16'h0038, 16'h00C4},
    '{8'h07, 4'h2, 16'h0040, 16'h00E0}, '{8'h00, 4'h0, 16'h0000, 16'h0370}};

  pwr_rate_map #(.SLICE_R1(SL_BASE), .SLICE_R2(SL_BASE + 1), .SLICE_R3(SL_BASE + 2), .SLICE_R4(SL_BASE + 3),
    .SLICE_R5(SL_BASE + 4), .SLICE_R6(SL_BASE + 5), .SLICE_R7(SL_BASE + 6)) i_dut (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
    .duty_step_req(duty_step_req), .pwm_channel_two(pwm_channel_two), .duty_step_applied(duty_step_applied));
  pwr_fan_model i_fan (.clk_sys(clk_sys), .pwm_in(pwm_channel_two), .win(win), .hi_cnt(fan_hi), .per_cnt(fan_per));

  // 20 MHz clock.
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end

  // Compares seen against expected and counts both.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe, driven from a falling edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(negedge clk_sys);
    reg_wr_en = 1'b0;
  endtask

  // Read data lags the address by one cycle.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    @(negedge clk_sys);
    chk({8'h00, reg_rd_data}, {8'h00, e});
  endtask

  // Prints the counts and the verdict.
  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // A hang is cut short well above the longest expected run.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 80000) begin
      n_errors++;
      end_sim();
    end
  end

  // Main sequence.
  initial begin
    repeat (5) @(negedge clk_sys);
    sys_rst = 1'b0;
    rd(8'hCF, 8'h00);
    // Each row drives one source in turn, so every source is tried under the chosen map.
    foreach (rows[i]) begin
      wr(8'hCF, rows[i].ctrl);
      duty_step_req = 32'h0000_0000;
      duty_step_req[(i % 8) * 4 +: 4] = rows[i].step;
      win = rows[i].per;
      repeat (4 * rows[i].per) @(negedge clk_sys);
      chk(fan_hi, rows[i].hi);
      if (rows[i].hi != 16'h0000 && rows[i].hi != rows[i].per) begin
        chk(fan_per, rows[i].per);
      end
      chk({12'h000, duty_step_applied}, {12'h000, rows[i].step});
      $display("row %0d done", i);
    end
    // Reserved bits and an unmapped address.
    wr(8'hCF, 8'hFF);
    rd(8'hCF, 8'h0F);
    wr(8'hCE, 8'h00);
    rd(8'hCF, 8'h0F);
    rd(8'hCE, 8'h00);
    $display("register test done");
    // Greatest request wins, and an out-of-range step is held at the top step.
    duty_step_req = 32'h0900_5000;
    @(negedge clk_sys);
    chk({12'h000, duty_step_applied}, 16'h0009);
    duty_step_req = 32'hF900_5000;
    @(negedge clk_sys);
    chk({12'h000, duty_step_applied}, 16'h000D);
    $display("source test done");
    // Reset in mid-run clears the register and the output.
    sys_rst = 1'b1;
    @(negedge clk_sys);
    @(negedge clk_sys);
    chk({15'h0000, pwm_channel_two}, 16'h0000);
    sys_rst = 1'b0;
    rd(8'hCF, 8'h00);
    $display("reset test done");
    end_sim();
  end
endmodule
